//--- bench/elem_model.sv
`timescale 1ns/1ps
`default_nettype none
// protective element group: raises the criteria of one chosen element
module elem_model #(
  parameter int unsigned N = 8
) (
  // clock
  input  wire logic              pclk,
  // command from the bench
  input  wire logic [3:0]        sel,
  input  wire logic [3:0]        bits,
  // fault criteria towards the frame
  output var  logic [N-1:0][2:0] ph,
  output var  logic [N-1:0]      gnd
);
  // every element owns separate alarm source bits
  always_ff @(posedge pclk) begin
    ph       <= '0;
    gnd      <= '0;
    ph[sel]  <= bits[2:0];
    gnd[sel] <= bits[3];
  end
endmodule // elem_model
`default_nettype wire

//--- bench/protection_master_alarm_trip_combiner_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module protection_master_alarm_trip_combiner_tb_top;
  import prot_pkg::*;
  logic             pclk, presetn, xb1, xb2, xtb, ga, gt, gga, irq;
  apb_req_type      req;
  apb_rsp_type      rsp;
  logic [3:0]       sel, bits;
  logic [7:0][2:0]  ph;
  logic [7:0]       gnd, cmd;
  logic [2:0]       pga, pgt;
  phasor_type       pp, gp;
  dir_type          pd, spd, sgd;
  logic [31:0]      rd;
  int               err_total, check_count, cyc;

  prot_master #(.N(8)) i_prot_master (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .external_block_input_1(xb1),
    .external_block_input_2(xb2), .external_trip_block_input(xtb),
    .elem_phase_alarm(ph), .elem_ground_alarm(gnd), .phase_phasor(pp),
    .ground_phasor(gp), .general_alarm(ga), .general_trip(gt),
    .phase_general_alarm(pga), .ground_general_alarm(gga),
    .phase_general_trip(pgt), .element_trip_command(cmd),
    .phase_direction(pd), .status_phase_direction(spd),
    .status_ground_direction(sgd), .irq(irq));
  elem_model #(.N(8)) i_elem_model (.pclk(pclk), .sel(sel), .bits(bits),
    .ph(ph), .gnd(gnd));

  ////////////////////////////////////////////////////////////////////////////
  // clock, hang guard, shared tasks
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      conclude();
    end
  end
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one apb transfer, held until pready
  task automatic apb(logic wr, logic [7:0] a, logic [31:0] d, logic err);
    @(posedge pclk);
    req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do @(posedge pclk); while (rsp.pready !== 1'b1);
    rd = rsp.prdata;
    chk("pslverr", rsp.pslverr, err);
    req <= '0;
  endtask
  task automatic run(int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // test sequence
  initial begin
    {presetn, xb1, xb2, xtb, sel, bits, req} = '0;
    pp = '{9'h000, 1'b1};
    gp = '{9'h000, 1'b1};
    run(10);
    presetn <= 1'b1;
    chk("gen_alarm", ga, 0);
    apb(0, OFS_CTRL, 0, 0);
    chk("ctrl", rd, 32'h01);
    apb(0, 8'hFC, 0, 1);
    apb(1, OFS_DELAY, 2, 0);
    bits <= 4'h8;
    run(4);
    chk("alarm", {ga, gga}, 2'b11);
    chk("early", gt, 0);
    run(4);
    chk("trip", {gt, cmd}, 9'h101);
    $display("general test done");
    apb(1, OFS_SUPERV, 1, 0);
    run(3);
    chk("sv", {ga, gt, cmd}, 0);
    apb(0, OFS_ESTAT, 0, 0);
    chk("estat", rd, 32'h00010001);
    apb(1, OFS_SUPERV, 0, 0);
    apb(1, OFS_CTRL, 32'h05, 0);
    run(6);
    chk("ptb", {gt, cmd}, 9'h100);
    apb(1, OFS_CTRL, 32'h09, 0);
    xtb <= 1'b1;
    run(3);
    chk("etb", cmd, 0);
    xtb <= 1'b0;
    run(3);
    chk("etb_rel", cmd, 1);
    apb(1, OFS_CTRL, 32'h03, 0);
    for (int i = 0; i < 2; i++) begin
      {xb2, xb1} <= 2'(i + 1);
      run(3);
      chk("blk", {ga, gt, cmd}, 0);
      {xb2, xb1} <= 2'b00;
      run(3);
      chk("unblk", ga, 1);
    end
    $display("blocking test done");
    apb(1, OFS_CTRL, 32'h01, 0);
    apb(1, OFS_SPCAP, 32'h02, 0);
    sel <= 4'h1;
    bits <= 4'h2;
    run(8);
    chk("ph", {pga, gga, pgt}, 7'h22);
    apb(1, OFS_DIREN, 32'h02, 0);
    pp <= '{9'h0B4, 1'b1};
    gp <= '{9'h0B4, 1'b1};
    run(4);
    chk("rev", {pd, spd, sgd, cmd}, {DIR_REV, DIR_REV, DIR_REV, 8'h00});
    pp <= '{9'h000, 1'b0};
    run(4);
    chk("np", pd, DIR_NP);
    pp <= '{9'h000, 1'b1};
    run(4);
    chk("fwd", {pd, cmd}, {DIR_FWD, 8'h02});
    bits <= 4'h0;
    run(4);
    chk("nofault", {pd, spd, sgd}, {DIR_FWD, DIR_NONE, DIR_NONE});
    apb(1, OFS_CTRL, 32'h11, 0);
    pp <= '{9'h0B4, 1'b1};
    run(4);
    chk("acb", pd, DIR_FWD);
    $display("direction test done");
    apb(1, OFS_IRQEN, 32'h07, 0);
    run(2);
    chk("irq_set", irq, 1);
    apb(1, OFS_IRQCLR, 32'h07, 0);
    run(2);
    chk("irq_clr", irq, 0);
    bits <= 4'h8;
    apb(1, OFS_CTRL, 32'h00, 0);
    run(8);
    chk("off", {ga, gt, cmd, irq}, 11'h001);
    apb(1, OFS_IRQEN, 32'h00, 0);
    run(2);
    chk("irq_mask", irq, 0);
    $display("interrupt test done");
    conclude();
  end
endmodule // protection_master_alarm_trip_combiner_tb_top
`default_nettype wire

//--- hw/dir_classify.sv
`timescale 1ns/1ps
`default_nettype none
// forward / reverse / not-possible decision for one direction quantity
module dir_classify (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // quantities and settings
  input  wire prot_pkg::phasor_type ph,
  input  wire logic [8:0]           mta,
  input  wire logic                 acb,
  // result
  output var  prot_pkg::dir_type    dir_q
);
  import prot_pkg::*;

  typedef struct packed {
    dir_type dir;                             // registered decision
  } dc_state_type;

  dc_state_type s_q;                          // state
  dc_state_type s_d;                          // next state
  logic [8:0]   ref_ang;                      // direction angle
  logic [8:0]   diff;                         // offset from direction angle

  ////////////////////////////////////////////////////////////////////////////
  // decision: forward inside +-90 of the direction angle
  always_comb begin
    s_d     = s_q;
    ref_ang = acb ? ang_add(mta, DEG_180) : mta;
    diff    = ang_sub(ph.angle, ref_ang);
    if (!ph.ok) begin
      s_d.dir = DIR_NP;
    end else if (diff < DEG_90 || diff > DEG_270) begin
      s_d.dir = DIR_FWD;
    end else begin
      s_d.dir = DIR_REV;
    end
  end

  // register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dir_q = s_q.dir;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_dir_fwd;
    @(posedge pclk) disable iff (!presetn)
      (ph.ok && !acb && ang_sub(ph.angle, mta) < DEG_90) |=> dir_q == DIR_FWD;
  endproperty
  a_dir_fwd: assert property (p_dir_fwd) else $error("forward not decided");

endmodule // dir_classify
`default_nettype wire

//--- hw/prot_master.sv
// Notes on behaviour
// - function inactive or blocked suppresses all protection
// - external block while either block input true
// - permanent trip command block inhibits commands only
// - external trip block while its input true
// - elements deliver separate alarm and trip
// - supervision-only: local status, no command, excluded
// - general alarm ors non-supervision alarms
// - general trip ors non-supervision trips
// - trip after delay with criterion still present
// - trip gives command unless command blocked
// - per-phase and ground collective alarms
// - per-phase trips from single-phase capable elements
// - weak phasors give not-possible direction
// - directional element trips only in configured direction
// - phase direction always, status only during fault
// - forward/reverse by line perpendicular to angle
// - forward within torque angle plus minus 90 (phase with acb set: within torque angle plus 180, plus minus 90)
//
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module prot_master #(
  parameter int unsigned N = prot_pkg::N_ELEM_DEF       // element count, at most 16
) (
  // clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // register bus
  input  wire prot_pkg::apb_req_type apb_req,
  output var  prot_pkg::apb_rsp_type apb_rsp,
  // global blocking inputs
  input  wire logic                  external_block_input_1,
  input  wire logic                  external_block_input_2,
  input  wire logic                  external_trip_block_input,
  // element fault criteria
  input  wire logic [N-1:0][2:0]     elem_phase_alarm,
  input  wire logic [N-1:0]          elem_ground_alarm,
  // direction quantities
  input  wire prot_pkg::phasor_type  phase_phasor,
  input  wire prot_pkg::phasor_type  ground_phasor,
  // collective signals
  output var  logic                  general_alarm,
  output var  logic                  general_trip,
  output var  logic [2:0]            phase_general_alarm,
  output var  logic                  ground_general_alarm,
  output var  logic [2:0]            phase_general_trip,
  output var  logic [N-1:0]          element_trip_command,
  // direction results
  output var  prot_pkg::dir_type     phase_direction,
  output var  prot_pkg::dir_type     status_phase_direction,
  output var  prot_pkg::dir_type     status_ground_direction,
  // interrupt
  output var  logic                  irq
);
  import prot_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [4:0]           ctrl;               // global settings
    logic [N-1:0]         superv;             // supervision-only
    logic [N-1:0]         tblk;               // element command block
    logic [N-1:0]         dir_en;             // directional elements
    logic [N-1:0]         dir_rev;            // wanted direction reverse
    logic [N-1:0]         gnd;                // uses ground direction
    logic [N-1:0]         spcap;              // single-phase capable
    logic [8:0]           phase_max_torque_angle;          // phase_max_torque_angle
    logic [8:0]           ground_mta;         // ground torque angle
    logic [15:0]          delay;              // trip delay cycles
    logic [N-1:0][15:0]   cnt;                // per-element delay timers
    logic [N-1:0]         e_alarm;            // element-local alarm
    logic [N-1:0]         e_trip;             // element-local trip
    logic                 gen_alarm;          // general alarm
    logic                 gen_trip;           // general trip
    logic [2:0]           ph_alarm;           // per-phase alarms
    logic                 gnd_alarm;          // ground alarm
    logic [2:0]           ph_trip;            // per-phase trips
    logic [N-1:0]         cmd;                // element_trip_command
    dir_type              st_ph;              // phase direction, fault only
    dir_type              st_gnd;             // ground direction, fault only
    logic [EV_W-1:0]      ev_st;              // sticky events
    logic [EV_W-1:0]      ev_en;              // event enables
    logic                 irq;                // interrupt level
    logic                 blocked;            // protection blocked
    apb_rsp_type          rsp;                // bus answer
  } pm_state_type;

  pm_state_type s_q;                          // state
  pm_state_type s_d;                          // next state
  dir_type      pdir;                         // phase decision
  dir_type      gdir;                         // ground decision
  logic         blk;                          // protection blocked now
  logic         tblk_all;                     // all commands blocked now
  logic         any_alarm;                    // fault event present
  logic [EV_W-1:0] ev;                        // events this cycle
  logic         acc;                          // apb access phase
  logic         done;                         // apb transfer completes
  logic [31:0]  rd;                           // read data
  logic         hit;                          // address mapped
  logic [31:0]  estat;                        // element status word

  ////////////////////////////////////////////////////////////////////////////
  // direction classifiers
  dir_classify u_phase_dir (
    .pclk    (pclk),
    .presetn (presetn),
    .ph      (phase_phasor),
    .mta     (s_q.phase_max_torque_angle),
    .acb     (s_q.ctrl[C_ACB]),
    .dir_q   (pdir)
  );

  dir_classify u_ground_dir (
    .pclk    (pclk),
    .presetn (presetn),
    .ph      (ground_phasor),
    .mta     (s_q.ground_mta),
    .acb     (1'b0),
    .dir_q   (gdir)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state: protection logic and register file
  always_comb begin
    s_d = s_q;
    // global blocking
    blk = !s_q.ctrl[C_FUNC]
        | (s_q.ctrl[C_EXB] & (external_block_input_1 | external_block_input_2));
    tblk_all = s_q.ctrl[C_PTB]
             | (s_q.ctrl[C_ETB] & external_trip_block_input);
    any_alarm   = 1'b0;
    s_d.gen_trip  = 1'b0;
    s_d.ph_alarm  = '0;
    s_d.gnd_alarm = 1'b0;
    s_d.ph_trip   = '0;
    // per-element timers, trips and commands
    for (int i = 0; i < N; i++) begin
      logic al;
      logic dok;
      logic tr;
      dir_type di;
      al  = (|elem_phase_alarm[i]) | elem_ground_alarm[i];
      di  = s_q.gnd[i] ? gdir : pdir;
      dok = !s_q.dir_en[i] || (di == (s_q.dir_rev[i] ? DIR_REV : DIR_FWD));
      // timer clears on drop-out or block
      if (blk || !al) begin
        s_d.cnt[i] = '0;
      end else if (s_q.cnt[i] != 16'hFFFF) begin
        s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
      end
      tr = !blk && al && (s_q.cnt[i] >= s_q.delay) && dok;
      s_d.e_alarm[i] = !blk && al;
      s_d.e_trip[i]  = tr;
      s_d.cmd[i] = tr && !s_q.superv[i] && !s_q.tblk[i] && !tblk_all;
      if (!blk && !s_q.superv[i]) begin
        any_alarm     = any_alarm | al;
        s_d.gen_trip  = s_d.gen_trip | tr;
        s_d.ph_alarm  = s_d.ph_alarm | elem_phase_alarm[i];
        s_d.gnd_alarm = s_d.gnd_alarm | elem_ground_alarm[i];
        if (tr && s_q.spcap[i]) begin
          s_d.ph_trip = s_d.ph_trip | elem_phase_alarm[i];
        end
      end
    end
    s_d.gen_alarm = any_alarm;
    s_d.blocked   = blk;
    // direction status shown only while a fault is active
    s_d.st_ph  = any_alarm ? pdir : DIR_NONE;
    s_d.st_gnd = any_alarm ? gdir : DIR_NONE;
    // events and interrupt
    ev[EV_ALARM] = s_d.gen_alarm & ~s_q.gen_alarm;
    ev[EV_TRIP]  = s_d.gen_trip & ~s_q.gen_trip;
    ev[EV_BLOCK] = blk & ~s_q.blocked;
    // element status word
    estat = '0;
    for (int i = 0; i < N; i++) begin
      estat[i]      = s_q.e_alarm[i];
      estat[16 + i] = s_q.e_trip[i];
    end
    // apb decode
    acc = apb_req.psel & apb_req.penable;
    done = acc & s_q.rsp.pready;
    hit = 1'b1;
    rd  = '0;
    case (apb_req.paddr)
      OFS_CTRL:   rd[4:0] = s_q.ctrl;
      OFS_SUPERV: rd[N-1:0] = s_q.superv;
      OFS_TBLK:   rd[N-1:0] = s_q.tblk;
      OFS_DIREN:  rd[N-1:0] = s_q.dir_en;
      OFS_DIRREV: rd[N-1:0] = s_q.dir_rev;
      OFS_GND:    rd[N-1:0] = s_q.gnd;
      OFS_SPCAP:  rd[N-1:0] = s_q.spcap;
      OFS_MTA: begin
        rd[8:0] = s_q.phase_max_torque_angle;
        rd[MTA_GND_LSB +: 9] = s_q.ground_mta;
      end
      OFS_DELAY:  rd[15:0] = s_q.delay;
      OFS_STAT: begin
        rd[0]     = s_q.gen_alarm;
        rd[1]     = s_q.gen_trip;
        rd[4:2]   = s_q.ph_alarm;
        rd[5]     = s_q.gnd_alarm;
        rd[8:6]   = s_q.ph_trip;
        rd[9]     = s_q.blocked;
        rd[10]    = tblk_all;
        rd[13:12] = pdir;
        rd[15:14] = gdir;
      end
      OFS_ESTAT:  rd = estat;
      OFS_IRQST:  rd[EV_W-1:0] = s_q.ev_st;
      OFS_IRQCLR: rd = '0;
      OFS_IRQEN:  rd[EV_W-1:0] = s_q.ev_en;
      default:    hit = 1'b0;
    endcase
    // one wait state, answer registered
    s_d.rsp.pready = acc & ~s_q.rsp.pready;
    if (acc && !s_q.rsp.pready) begin
      s_d.rsp.prdata  = apb_req.pwrite ? 32'h0000_0000 : rd;
      s_d.rsp.pslverr = ~hit;
    end else begin
      s_d.rsp.prdata  = '0;
      s_d.rsp.pslverr = 1'b0;
    end
    // sticky events: set wins over clear
    s_d.ev_st = s_q.ev_st;
    if (done && apb_req.pwrite && apb_req.paddr == OFS_IRQCLR) begin
      s_d.ev_st = s_q.ev_st & ~apb_req.pwdata[EV_W-1:0];
    end
    s_d.ev_st = s_d.ev_st | ev;
    // register writes at completing edge
    if (done && apb_req.pwrite) begin
      case (apb_req.paddr)
        OFS_CTRL:   s_d.ctrl = apb_req.pwdata[4:0];
        OFS_SUPERV: s_d.superv = apb_req.pwdata[N-1:0];
        OFS_TBLK:   s_d.tblk = apb_req.pwdata[N-1:0];
        OFS_DIREN:  s_d.dir_en = apb_req.pwdata[N-1:0];
        OFS_DIRREV: s_d.dir_rev = apb_req.pwdata[N-1:0];
        OFS_GND:    s_d.gnd = apb_req.pwdata[N-1:0];
        OFS_SPCAP:  s_d.spcap = apb_req.pwdata[N-1:0];
        OFS_MTA: begin
          s_d.phase_max_torque_angle  = apb_req.pwdata[8:0];
          s_d.ground_mta = apb_req.pwdata[MTA_GND_LSB +: 9];
        end
        OFS_DELAY:  s_d.delay = apb_req.pwdata[15:0];
        OFS_IRQEN:  s_d.ev_en = apb_req.pwdata[EV_W-1:0];
        default:    s_d.ev_en = s_d.ev_en;
      endcase
    end
    s_d.irq = |(s_d.ev_st & s_d.ev_en);
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers, cleared in reset except ctrl and delay, which load CTRL_RESET and DELAY_RESET
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q       <= '0;
      s_q.ctrl  <= CTRL_RESET;
      s_q.delay <= DELAY_RESET;
    end else begin
      s_q       <= s_d;
    end
  end

  // outputs straight from state
  assign apb_rsp                 = s_q.rsp;
  assign general_alarm           = s_q.gen_alarm;
  assign general_trip            = s_q.gen_trip;
  assign phase_general_alarm     = s_q.ph_alarm;
  assign ground_general_alarm    = s_q.gnd_alarm;
  assign phase_general_trip      = s_q.ph_trip;
  assign element_trip_command    = s_q.cmd;
  assign phase_direction         = pdir;
  assign status_phase_direction  = s_q.st_ph;
  assign status_ground_direction = s_q.st_gnd;
  assign irq                     = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // per-element criterion present, used only by the checks below
  logic [N-1:0] elem_any;                     // any criterion of element
  always_comb begin
    for (int i = 0; i < N; i++) begin
      elem_any[i] = (|elem_phase_alarm[i]) | elem_ground_alarm[i];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_block_all;
    blk |=> !general_alarm && !general_trip && element_trip_command == '0;
  endproperty
  a_block_all: assert property (p_block_all) else $error("output while blocked");

  property p_ext_block;
    s_q.ctrl[C_EXB] && external_block_input_2 |=> !general_alarm ##0 s_q.blocked;
  endproperty
  a_ext_block: assert property (p_ext_block) else $error("external block ignored");

  property p_perm_tblk;
    s_q.ctrl[C_PTB] && !blk |=> element_trip_command == '0
      && general_trip == |(s_q.e_trip & ~$past(s_q.superv));
  endproperty
  a_perm_tblk: assert property (p_perm_tblk) else $error("command not inhibited");

  property p_ext_tblk;
    s_q.ctrl[C_ETB] && external_trip_block_input |=> element_trip_command == '0;
  endproperty
  a_ext_tblk: assert property (p_ext_tblk) else $error("external trip block");

  property p_superv_cmd;
    1'b1 |=> (element_trip_command & $past(s_q.superv)) == '0;
  endproperty
  a_superv_cmd: assert property (p_superv_cmd) else $error("supervision command");

  property p_gen_alarm;
    !blk |=> general_alarm == $past(|(elem_any & ~s_q.superv));
  endproperty
  a_gen_alarm: assert property (p_gen_alarm) else $error("general alarm wrong");

  property p_gen_trip;
    general_trip |-> $past(!blk) && $past(|(elem_any & ~s_q.superv))
      && |(s_q.e_trip & ~$past(s_q.superv));
  endproperty
  a_gen_trip: assert property (p_gen_trip) else $error("general trip wrong");

  property p_trip_delay;
    s_q.e_trip[0] |-> $past(s_q.cnt[0]) >= $past(s_q.delay) && s_q.e_alarm[0];
  endproperty
  a_trip_delay: assert property (p_trip_delay) else $error("trip before delay");

  property p_not_possible;
    !phase_phasor.ok |=> phase_direction == DIR_NP;
  endproperty
  a_not_possible: assert property (p_not_possible) else $error("direction possible");

  property p_fault_status;
    !any_alarm |=> status_phase_direction == DIR_NONE && status_ground_direction == DIR_NONE;
  endproperty
  a_fault_status: assert property (p_fault_status) else $error("status outside fault");

  property p_apb_wait;
    acc && !apb_rsp.pready |=> apb_rsp.pready ##1 !apb_rsp.pready;
  endproperty
  a_apb_wait: assert property (p_apb_wait) else $error("apb answer timing");

  c_trip_cmd:  cover property (!element_trip_command[0] ##1 element_trip_command[0]);
  c_gen_trip:  cover property (general_alarm ##[1:20] general_trip);
  c_blocked:   cover property (general_alarm ##1 blk ##1 !general_alarm);
  c_irq:       cover property (!irq ##1 irq);

endmodule // prot_master
`default_nettype wire

//--- hw/prot_pkg.sv
// shared constants and carriers of the protection master frame
package prot_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int unsigned N_ELEM_DEF = 8;     // default element count
  localparam int unsigned AW         = 8;     // apb address width

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // global settings
  localparam logic [7:0] OFS_SUPERV = 8'h04;  // supervision-only mask
  localparam logic [7:0] OFS_TBLK   = 8'h08;  // per-element trip command block
  localparam logic [7:0] OFS_DIREN  = 8'h0C;  // directional element mask
  localparam logic [7:0] OFS_DIRREV = 8'h10;  // configured direction, 1 = reverse
  localparam logic [7:0] OFS_GND    = 8'h14;  // element uses ground direction
  localparam logic [7:0] OFS_SPCAP  = 8'h18;  // single-phase capable mask
  localparam logic [7:0] OFS_MTA    = 8'h1C;  // phase / ground torque angles
  localparam logic [7:0] OFS_DELAY  = 8'h20;  // element trip delay in cycles
  localparam logic [7:0] OFS_STAT   = 8'h24;  // collective status, read only
  localparam logic [7:0] OFS_ESTAT  = 8'h28;  // element-local status, read only
  localparam logic [7:0] OFS_IRQST  = 8'h2C;  // sticky events, read only
  localparam logic [7:0] OFS_IRQCLR = 8'h30;  // event clear, write only
  localparam logic [7:0] OFS_IRQEN  = 8'h34;  // event enable

  ////////////////////////////////////////////////////////////////////////////
  // control field positions and reset values
  localparam int unsigned C_FUNC = 0;         // protection function active
  localparam int unsigned C_EXB  = 1;         // external_block_enable
  localparam int unsigned C_PTB  = 2;         // permanent_trip_command_block
  localparam int unsigned C_ETB  = 3;         // external_trip_block_enable
  localparam int unsigned C_ACB  = 4;         // phase sequence acb
  localparam logic [4:0]  CTRL_RESET  = 5'h01;
  localparam logic [15:0] DELAY_RESET = 16'h0000;
  localparam int unsigned MTA_GND_LSB = 16;   // ground angle field of mta word

  ////////////////////////////////////////////////////////////////////////////
  // event bits
  localparam int unsigned EV_ALARM = 0;       // general alarm rose
  localparam int unsigned EV_TRIP  = 1;       // general trip rose
  localparam int unsigned EV_BLOCK = 2;       // protection became blocked
  localparam int unsigned EV_W     = 3;

  ////////////////////////////////////////////////////////////////////////////
  // angles in whole degrees
  localparam logic [8:0] DEG_90  = 9'h05A;
  localparam logic [8:0] DEG_180 = 9'h0B4;
  localparam logic [8:0] DEG_270 = 9'h10E;
  localparam logic [8:0] DEG_360 = 9'h168;

  // modulo-360 sum of two angles below 360
  function automatic logic [8:0] ang_add(input logic [8:0] a, input logic [8:0] b);
    logic [9:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= {1'b0, DEG_360}) begin
      s = s - {1'b0, DEG_360};
    end
    return s[8:0];
  endfunction

  // modulo-360 difference a - b
  function automatic logic [8:0] ang_sub(input logic [8:0] a, input logic [8:0] b);
    return ang_add(a, DEG_360 - b);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // carriers
  typedef enum logic [1:0] {
    DIR_NONE = 2'b00,                         // no result shown
    DIR_FWD  = 2'b01,                         // forward
    DIR_REV  = 2'b10,                         // reverse
    DIR_NP   = 2'b11                          // not possible
  } dir_type;

  typedef struct packed {
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [31:0]   pwdata;
  } apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_type;

  typedef struct packed {
    logic [8:0] angle;                        // operating vs polarizing, degrees
    logic       ok;                           // magnitudes large enough
  } phasor_type;

endpackage
